//--- hdl/spdif_buf_pkg.sv
// Purpose: Constants, state type and CRC function for the S/PDIF
//          status and user bit buffer block.
// Assumes: Byte-wide register space with a 7-bit address.
// Notes:   Main sizes and addresses are named here; some counts stay literal, such as 10 and 7'h5f.
package spdif_buf_pkg;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [6:0] RX_CS_BASE  = 7'h20; // Receive status bytes
  localparam logic [6:0] RX_CS_LAST  = 7'h37; // Last receive byte
  localparam logic [6:0] TX_CS_BASE  = 7'h38; // Transmit status bytes
  localparam logic [6:0] TX_CS_LAST  = 7'h4f; // Last transmit byte
  localparam logic [6:0] Q_BASE      = 7'h60; // Q subcode bytes
  localparam logic [6:0] Q_LAST      = 7'h69; // Last Q subcode byte
  localparam logic [6:0] RX_CFG      = 7'h10; // Receive buffer config
  localparam logic [6:0] TX_CFG      = 7'h11; // Transmit buffer config
  localparam logic [6:0] CS_SWITCH   = 7'h12; // Channel switch bits
  localparam logic [6:0] INT_STAT    = 7'h13; // Sticky flags
  localparam logic [6:0] INT_MASK    = 7'h14; // Flag masks
  localparam logic [6:0] Q_ERR       = 7'h15; // Q CRC error flag
  localparam logic [6:0] RX_UPTR     = 7'h16; // Rx user pointer
  localparam logic [6:0] RX_UDATA    = 7'h17; // Rx user data
  localparam logic [6:0] TX_UPTR     = 7'h18; // Tx user pointer
  localparam logic [6:0] TX_UDATA    = 7'h19; // Tx user data
  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int CFG_SIZE    = 0;  // Buffer size bit
  localparam int CFG_MODE    = 1;  // Two-bit mode, low bit
  localparam int CFG_FLAG    = 3;  // Rx flag mode / tx Z alignment
  localparam int SW_RX_SEL   = 0;  // Rx channel select
  localparam int SW_TX_SEL   = 1;  // Tx channel select
  localparam int SW_AB_SAME  = 2;  // Send buffer on both channels
  localparam int SW_NO_COPY  = 3;  // Copy disable
  localparam int IS_RX_CS    = 0;  // Rx status block flag
  localparam int IS_RX_UB    = 1;  // Rx user buffer full flag
  localparam int IS_TX_UB    = 2;  // Tx user buffer empty flag
  localparam logic [7:0] CFG_RESET = 8'h00; // Config reset value
  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int CS_BITS   = 192; // Status bits per channel
  localparam int CS_BYTES  = 24;  // Status bytes per channel
  localparam int CHG_BITS  = 40;  // Five bytes compared for change
  localparam int UB_SMALL  = 384; // Short user buffer, bits
  localparam int UB_LARGE  = 768; // Long user buffer, bits
  localparam int IU_COUNT  = 96;  // IUs per Q subcode
  localparam int IU_GAP    = 8;   // Zeros beyond this end a message
  localparam int Q_BITS    = 80;  // Q subcode data bits
  localparam int CRC_BITS  = 16;  // Q subcode CRC bits
  localparam logic [3:0] UF_NONE = 4'h0; // Auto format: ignore
  localparam logic [3:0] UF_A    = 4'h4; // Auto format: linear
  localparam logic [3:0] UF_B    = 4'h8; // Auto format: short
  localparam logic [3:0] UF_C    = 4'hc; // Auto format: linear
  localparam logic [16:0] CRC_POLY = 17'h11021; // x16+x12+x5+1

  typedef enum logic {IU_HUNT, IU_SHIFT} iu_state_t;

  // CRC over the Q data, first bit first
  function automatic logic [15:0] q_crc(input logic [79:0] d);
    logic [15:0] c;
    c = 16'h0000;
    for (int i = 79; i >= 0; i--) begin
      c = (c[15] ^ d[i]) ? ({c[14:0], 1'b0} ^ CRC_POLY[15:0])
                         : {c[14:0], 1'b0};
    end
    return c;
  endfunction
endpackage

//--- hdl/spdif_status_user_buffers.sv
// Purpose: Double-buffered channel status and user bit storage for
//          an S/PDIF receiver and transmitter.
// Assumes: Bit strobes from the frame coders are at least 2 clocks
//          apart; registers are byte wide on a plain strobe port.
// Notes:   User bits are packed first bit into bit 7 of each byte.
//
// The register offsets and the plain strobed port were chosen for this implementation.
module spdif_status_user_buffers (
  input  wire logic       i_clk,         // 20 MHz clock
  input  wire logic       i_rst_n,       // Sync reset, active low
  input  wire logic [6:0] i_addr,        // Register address
  input  wire logic [7:0] i_wdata,       // Register write data
  input  wire logic       i_wr,          // Write strobe
  input  wire logic       i_rd,          // Read strobe
  output logic      [7:0] o_rdata,       // Read data, next cycle
  output logic            o_irq,         // Masked flag summary
  input  wire logic       i_rx_bit,      // Rx subframe strobe
  input  wire logic       i_rx_chan_b,   // Rx subframe is channel B
  input  wire logic       i_rx_zblk,     // Rx frame has Z preamble
  input  wire logic       i_rx_cs,       // Rx status bit
  input  wire logic       i_rx_user,     // Rx user bit
  input  wire logic       i_tx_bit,      // Tx subframe request
  input  wire logic       i_tx_chan_b,   // Tx subframe is channel B
  input  wire logic       i_tx_zblk,     // Tx frame has Z preamble
  output logic            o_tx_cs,       // Tx status bit
  output logic            o_tx_user      // Tx user bit
);
  // ****************************************************************
  // Registers and buffers
  // ****************************************************************
  logic [7:0]   rx_cfg, tx_cfg, cs_switch, int_mask; // Control regs
  logic [2:0]   int_stat;                  // Sticky flags
  logic         q_subcode_crc_error;       // Sticky CRC error
  logic [6:0]   rx_uptr, tx_uptr;          // User byte pointers
  logic [191:0] rx_cs_work [2];            // Status being gathered
  logic [191:0] rx_cs_rd   [2];            // Readable status
  logic [191:0] tx_cs_host [2];            // Host-written status
  logic [191:0] tx_cs_live [2];            // Status being sent
  logic [767:0] rx_u_work, rx_u_rd;        // Rx user buffers
  logic [767:0] tx_u_host, tx_u_live;      // Tx user buffers
  logic [79:0]  q_rd;                      // Q subcode buffer
  logic         tx_host_full;              // Second tx buffer loaded
  logic [7:0]   rx_cnt, tx_cnt;            // Frame in status block
  logic [9:0]   rx_uidx, tx_uidx;          // Linear user bit index
  logic [6:0]   iu_idx, tx_byte;           // IU byte indices
  logic [3:0]   iu_bits, zeros, tx_sub;    // IU bit counters
  logic [7:0]   iu_sh;                     // IU shift register
  logic         rx_u_done, q_done;         // Copy requests
  logic         tx_started;                // Tx user bits running
  spdif_buf_pkg::iu_state_t iu_state;      // IU search state

  // ****************************************************************
  // Decoding
  // ****************************************************************
  // switch bit picks channel
  wire       rx_sel  = cs_switch[spdif_buf_pkg::SW_RX_SEL];
  wire       tx_sel  = cs_switch[spdif_buf_pkg::SW_TX_SEL];
  wire [1:0] rx_mode = rx_cfg[spdif_buf_pkg::CFG_MODE +: 2];
  wire [1:0] tx_mode = tx_cfg[spdif_buf_pkg::CFG_MODE +: 2];
  wire in_rx_cs = i_addr >= spdif_buf_pkg::RX_CS_BASE &&
                  i_addr <= spdif_buf_pkg::RX_CS_LAST;
  wire in_tx_cs = i_addr >= spdif_buf_pkg::TX_CS_BASE &&
                  i_addr <= spdif_buf_pkg::TX_CS_LAST;
  wire in_q     = i_addr >= spdif_buf_pkg::Q_BASE &&
                  i_addr <= spdif_buf_pkg::Q_LAST;
  wire [6:0] rx_off = i_addr - spdif_buf_pkg::RX_CS_BASE;
  wire [6:0] tx_off = i_addr - spdif_buf_pkg::TX_CS_BASE;
  wire [6:0] q_off  = i_addr - spdif_buf_pkg::Q_BASE;
  wire rd_stat = i_rd && i_addr == spdif_buf_pkg::INT_STAT;
  wire rd_qerr = i_rd && i_addr == spdif_buf_pkg::Q_ERR;
  wire rd_udat = i_rd && i_addr == spdif_buf_pkg::RX_UDATA;
  wire wr_tdat = i_wr && i_addr == spdif_buf_pkg::TX_UDATA;

  // automatic format from status byte 1 bits 7..4
  wire       pro    = rx_cs_rd[0][0];
  wire [3:0] ufmt   = rx_cs_rd[0][15:12];
  wire       auto_l = ufmt == spdif_buf_pkg::UF_A ||
                      ufmt == spdif_buf_pkg::UF_B ||
                      ufmt == spdif_buf_pkg::UF_C;
  wire rx_lin = rx_mode == 2'b01 || (rx_mode == 2'b10 && pro && auto_l);
  wire rx_iu  = rx_mode == 2'b10 && !pro;
  // buffer length, forced short by format 1000
  wire rx_small = !rx_cfg[spdif_buf_pkg::CFG_SIZE] ||
                  (rx_mode == 2'b10 && pro && ufmt == spdif_buf_pkg::UF_B);
  wire [9:0] rx_ulast = rx_small ? 10'(spdif_buf_pkg::UB_SMALL - 1)
                                 : 10'(spdif_buf_pkg::UB_LARGE - 1);
  wire tx_small = !tx_cfg[spdif_buf_pkg::CFG_SIZE];
  wire [9:0] tx_ulast = tx_small ? 10'(spdif_buf_pkg::UB_SMALL - 1)
                                 : 10'(spdif_buf_pkg::UB_LARGE - 1);
  wire [6:0] tx_blast = tx_ulast[9:3];

  // First bit of each byte sits in bit 7
  function automatic logic [9:0] upos(input logic [9:0] n);
    return {n[9:3], ~n[2:0]};
  endfunction

  // Q bits taken from bit 6 of each stored IU
  logic [95:0] q_all;   // Received Q stream, first bit at top
  logic [79:0] q_tx;    // Q data from first 10 tx bytes
  for (genvar k = 0; k < spdif_buf_pkg::IU_COUNT; k++) begin : g_q
    assign q_all[95-k] = rx_u_work[8*k+6];
  end
  for (genvar j = 0; j < 10; j++) begin : g_qt
    assign q_tx[79-8*j -: 8] = tx_u_live[8*j +: 8];
  end
  wire [15:0] q_tx_crc = ~spdif_buf_pkg::q_crc(q_tx);
  // CD style CRC is sent inverted
  wire q_bad = q_all[15:0] != ~spdif_buf_pkg::q_crc(q_all[95:16]);

  // change test on the first five bytes of both channels
  wire cs_changed =
    rx_cs_work[0][spdif_buf_pkg::CHG_BITS-1:0] !=
      rx_cs_rd[0][spdif_buf_pkg::CHG_BITS-1:0] ||
    rx_cs_work[1][spdif_buf_pkg::CHG_BITS-1:0] !=
      rx_cs_rd[1][spdif_buf_pkg::CHG_BITS-1:0];
  wire rx_blk_end = i_rx_bit && i_rx_chan_b &&
                    rx_cnt == 8'(spdif_buf_pkg::CS_BITS - 1);
  wire rx_cs_set  = rx_blk_end &&
                    (!rx_cfg[spdif_buf_pkg::CFG_FLAG] || cs_changed);

  // Transmit user sequencing decisions
  wire tx_z      = i_tx_bit && i_tx_zblk && !i_tx_chan_b;
  wire tx_need_z = tx_cfg[spdif_buf_pkg::CFG_FLAG] && tx_mode == 2'b01;
  wire tx_go     = i_tx_bit && tx_mode != 2'b00 &&
                   (tx_started || !tx_need_z || tx_z);
  wire tx_blast_q = tx_byte == 7'(spdif_buf_pkg::IU_COUNT - 1);
  wire tx_end    = tx_mode == 2'b01 ? tx_uidx == tx_ulast
                 : tx_sub == 4'h8 &&
                   (tx_mode == 2'b11 ? tx_blast_q : tx_byte == tx_blast);
  wire tx_swap   = tx_go && tx_end;
  wire [7:0] tx_iu = tx_mode == 2'b11
                   ? {1'b1, q_tx_sub({q_tx, q_tx_crc}, tx_byte), 6'h00}
                   : tx_u_live[8*tx_byte +: 8];

  // Q stream bit for IU number b: data then CRC; the stream comes in
  // as an argument so the select follows every change of it
  function automatic logic q_tx_sub(input logic [95:0] s,
                                    input logic [6:0]  b);
    return s[7'h5f - b];
  endfunction

  // Read data selection
  wire [7:0] rd_val =
    in_rx_cs ? rx_cs_rd[rx_sel][8*rx_off[4:0] +: 8] :
    in_tx_cs ? tx_cs_host[tx_sel][8*tx_off[4:0] +: 8] :
    in_q     ? q_rd[79-8*q_off[3:0] -: 8] :
    i_addr == spdif_buf_pkg::RX_CFG    ? rx_cfg :
    i_addr == spdif_buf_pkg::TX_CFG    ? tx_cfg :
    i_addr == spdif_buf_pkg::CS_SWITCH ? cs_switch :
    i_addr == spdif_buf_pkg::INT_STAT  ? {5'h00, int_stat} :
    i_addr == spdif_buf_pkg::INT_MASK  ? int_mask :
    i_addr == spdif_buf_pkg::Q_ERR     ? {7'h00, q_subcode_crc_error} :
    i_addr == spdif_buf_pkg::RX_UPTR   ? {1'b0, rx_uptr} :
    i_addr == spdif_buf_pkg::TX_UPTR   ? {1'b0, tx_uptr} :
    i_addr == spdif_buf_pkg::RX_UDATA  ? rx_u_rd[8*rx_uptr +: 8] :
    8'h00;
  wire [2:0] stat_set;
  assign stat_set[spdif_buf_pkg::IS_RX_CS] = rx_cs_set;
  // user full flag gated by its mask
  assign stat_set[spdif_buf_pkg::IS_RX_UB] =
    rx_u_done && int_mask[spdif_buf_pkg::IS_RX_UB];
  // tx flag when second buffer drained
  assign stat_set[spdif_buf_pkg::IS_TX_UB] = tx_swap && tx_host_full;

  // ****************************************************************
  // Register port
  // ****************************************************************
  // Control writes, read side effects; a flag set beats a read clear
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      {rx_cfg, tx_cfg} <= {2{spdif_buf_pkg::CFG_RESET}};
      {cs_switch, int_mask} <= {2{spdif_buf_pkg::CFG_RESET}};
      int_stat <= 3'h0;
      q_subcode_crc_error <= 1'b0;
      {rx_uptr, tx_uptr} <= 14'h0000;
      tx_host_full <= 1'b0;
      o_rdata <= 8'h00;
      o_irq <= 1'b0;
    end else begin
      o_rdata <= i_rd ? rd_val : 8'h00;
      int_stat <= (rd_stat ? 3'h0 : int_stat) | stat_set;
      q_subcode_crc_error <= (q_subcode_crc_error && !rd_qerr) ||
                             (q_done && q_bad);
      o_irq <= |(int_stat & int_mask[2:0]);
      if (rd_udat) begin
        rx_uptr <= rx_uptr == rx_ulast[9:3] ? 7'h00 : rx_uptr + 7'h01;
      end
      if (tx_swap) begin
        tx_host_full <= 1'b0;
      end
      if (i_wr) begin
        unique case (i_addr)
          spdif_buf_pkg::RX_CFG:    rx_cfg <= i_wdata;
          spdif_buf_pkg::TX_CFG:    tx_cfg <= i_wdata;
          spdif_buf_pkg::CS_SWITCH: cs_switch <= i_wdata;
          spdif_buf_pkg::INT_MASK:  int_mask <= i_wdata;
          spdif_buf_pkg::RX_UPTR:   rx_uptr <= i_wdata[6:0];
          spdif_buf_pkg::TX_UPTR:   tx_uptr <= i_wdata[6:0];
          spdif_buf_pkg::TX_UDATA: begin
            // Last byte marks the second buffer as loaded
            tx_uptr <= tx_uptr == tx_blast ? 7'h00 : tx_uptr + 7'h01;
            if (tx_uptr == tx_blast) begin
              tx_host_full <= 1'b1;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // host writes land in the selected channel buffer
  always_ff @(posedge i_clk) begin
    if (i_wr && in_tx_cs) begin
      tx_cs_host[tx_sel][8*tx_off[4:0] +: 8] <= i_wdata;
    end
    if (wr_tdat) begin
      tx_u_host[8*tx_uptr +: 8] <= i_wdata;
    end
  end

  // ****************************************************************
  // Receive status
  // ****************************************************************
  // gather both channels, copy after the last channel B bit
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rx_cnt <= 8'h00;
      rx_cs_rd[0] <= '0;
      rx_cs_rd[1] <= '0;
    end else if (i_rx_bit) begin
      if (i_rx_zblk && !i_rx_chan_b) begin
        rx_cnt <= 8'h00;
        rx_cs_work[0][0] <= i_rx_cs;
      end else begin
        // status bit n lands in byte n/8
        rx_cs_work[i_rx_chan_b][rx_cnt] <= i_rx_cs;
      end
      if (i_rx_chan_b) begin
        rx_cnt <= rx_cnt + 8'h01;
      end
      if (rx_blk_end) begin
        rx_cs_rd[0] <= rx_cs_work[0];
        rx_cs_rd[1] <= {i_rx_cs, rx_cs_work[1][190:0]};
      end
    end
  end

  // ****************************************************************
  // Receive user bits
  // ****************************************************************
  // Linear fill and IU message search share the work buffer
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rx_uidx <= 10'h000;
      iu_state <= spdif_buf_pkg::IU_HUNT;
      {iu_idx, iu_bits, zeros, iu_sh} <= 23'h000000;
      {rx_u_done, q_done} <= 2'b00;
      rx_u_rd <= '0;
      q_rd <= '0;
    end else begin
      rx_u_done <= 1'b0;
      q_done <= 1'b0;
      // Copy one cycle after the last linear bit landed or the IU gap ended
      if (rx_u_done) begin
        rx_u_rd <= rx_u_work;
      end
      if (q_done) begin
        q_rd <= q_all[95:16];
      end
      // block restarts at the Z preamble
      if (i_rx_bit && rx_lin) begin
        if (i_rx_zblk && !i_rx_chan_b) begin
          rx_u_work[upos(10'h000)] <= i_rx_user;
          rx_uidx <= 10'h001;
        end else begin
          rx_u_work[upos(rx_uidx)] <= i_rx_user;
          rx_uidx <= rx_uidx == rx_ulast ? 10'h000 : rx_uidx + 10'h001;
          rx_u_done <= rx_uidx == rx_ulast;
        end
      end else if (i_rx_bit && rx_iu) begin
        unique case (iu_state)
          spdif_buf_pkg::IU_HUNT: begin
            if (i_rx_user) begin
              iu_sh <= 8'h01;
              iu_bits <= 4'h1;
              iu_state <= spdif_buf_pkg::IU_SHIFT;
            end else begin
              // stuffed zeros dropped, long gap ends message
              zeros <= zeros > 4'(spdif_buf_pkg::IU_GAP) ? zeros
                                                        : zeros + 4'h1;
              if (zeros == 4'(spdif_buf_pkg::IU_GAP) && iu_idx != 0) begin
                rx_u_done <= 1'b1;
                iu_idx <= 7'h00;
              end
            end
          end
          spdif_buf_pkg::IU_SHIFT: begin
            iu_sh <= {iu_sh[6:0], i_rx_user};
            iu_bits <= iu_bits + 4'h1;
            if (iu_bits == 4'h7) begin
              // leading one and Q..W in one byte
              if (iu_idx < 7'(spdif_buf_pkg::IU_COUNT)) begin
                rx_u_work[8*iu_idx +: 8] <= {iu_sh[6:0], i_rx_user};
                iu_idx <= iu_idx + 7'h01;
              end
              // Q subcode complete after the 96th IU
              q_done <= iu_idx == 7'(spdif_buf_pkg::IU_COUNT - 1);
              zeros <= 4'h0;
              iu_state <= spdif_buf_pkg::IU_HUNT;
            end
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Transmit status
  // ****************************************************************
  // repeat the live copy; refresh at each block unless held
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      tx_cnt <= 8'h00;
      o_tx_cs <= 1'b0;
      tx_cs_live[0] <= '0;
      tx_cs_live[1] <= '0;
    end else if (i_tx_bit) begin
      if (tx_z) begin
        tx_cnt <= 8'h00;
        o_tx_cs <= tx_cs_live[0][0];
        if (!cs_switch[spdif_buf_pkg::SW_NO_COPY]) begin
          // one buffer feeds both channels when same
          tx_cs_live[0] <= cs_switch[spdif_buf_pkg::SW_AB_SAME]
                         ? tx_cs_host[tx_sel] : tx_cs_host[0];
          tx_cs_live[1] <= cs_switch[spdif_buf_pkg::SW_AB_SAME]
                         ? tx_cs_host[tx_sel] : tx_cs_host[1];
          o_tx_cs <= cs_switch[spdif_buf_pkg::SW_AB_SAME]
                   ? tx_cs_host[tx_sel][0] : tx_cs_host[0][0];
        end
      end else begin
        o_tx_cs <= tx_cs_live[i_tx_chan_b][tx_cnt];
        if (i_tx_chan_b) begin
          tx_cnt <= tx_cnt == 8'(spdif_buf_pkg::CS_BITS - 1)
                  ? 8'h00 : tx_cnt + 8'h01;
        end
      end
    end
  end

  // ****************************************************************
  // Transmit user bits
  // ****************************************************************
  // zeros, linear buffer, IU stream or Q subcode stream
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      {tx_uidx, tx_byte, tx_sub} <= 21'h000000;
      tx_started <= 1'b0;
      o_tx_user <= 1'b0;
      tx_u_live <= '0;
    end else begin
      if (tx_mode == 2'b00) begin
        tx_started <= 1'b0;
        {tx_uidx, tx_byte, tx_sub} <= 21'h000000;
      end
      if (i_tx_bit) begin
        o_tx_user <= 1'b0;
      end
      if (tx_go) begin
        // first bit waits for Z only when aligned in mode 01
        tx_started <= 1'b1;
        if (tx_mode == 2'b01) begin
          o_tx_user <= tx_u_live[upos(tx_uidx)];
          tx_uidx <= tx_end ? 10'h000 : tx_uidx + 10'h001;
        end else begin
          // IU bits, then one stuffed zero
          o_tx_user <= tx_sub[3] ? 1'b0 : tx_iu[3'd7 - tx_sub[2:0]];
          tx_sub <= tx_sub[3] ? 4'h0 : tx_sub + 4'h1;
          if (tx_sub[3]) begin
            tx_byte <= tx_end ? 7'h00 : tx_byte + 7'h01;
          end
        end
        // Hand over the loaded buffer at the end of a pass
        if (tx_swap && tx_host_full) begin
          tx_u_live <= tx_u_host;
        end
      end
    end
  end
endmodule // spdif_status_user_buffers

//--- dv/spdif_buf_asserts.sv
// Purpose: Port checks for the status and user buffer block
// Assumes: Config and mask are seen through host writes
// Notes:   Clear-on-read checks need a quiet link around the reads
module spdif_buf_chk (
  input wire logic       i_clk,    // Clock
  input wire logic       i_rst_n,  // Reset
  input wire logic [6:0] i_addr,   // Address
  input wire logic [7:0] i_wdata,  // Write data
  input wire logic       i_wr,     // Write
  input wire logic       i_rd,     // Read
  input wire logic [7:0] o_rdata,  // Read data
  input wire logic       o_irq,    // Interrupt
  input wire logic       i_rx_bit, // Rx strobe
  input wire logic       i_tx_bit, // Tx strobe
  input wire logic       o_tx_cs,  // Tx status
  input wire logic       o_tx_user // Tx user
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] txcfg, mask; // Shadows of tx config and mask
  // Shadows follow host writes
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      txcfg <= 8'h00;
      mask  <= 8'h00;
    end else begin
      if (i_wr && i_addr == 7'h11) txcfg <= i_wdata;
      if (i_wr && i_addr == 7'h14) mask <= i_wdata;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  property p_idle; !i_rd |=> o_rdata == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("read data stuck");
  property p_hole; i_rd && i_addr == 7'h7f |=> o_rdata == 8'h00; endproperty
  a_hole: assert property (p_hole) else $error("hole read");
  property p_zero; i_tx_bit && txcfg[2:1] == 2'b00 |=> !o_tx_user; endproperty
  a_zero: assert property (p_zero) else $error("tx user not 0");
  property p_hold; !i_tx_bit |=> $stable({o_tx_cs, o_tx_user}); endproperty
  a_hold: assert property (p_hold) else $error("tx bit moved");
  property p_irq; mask[2:0] == 3'h0 ##1 mask[2:0] == 3'h0 |-> !o_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq while masked");
  property p_qerr;
    !$past(i_rx_bit) && !i_rx_bit && i_rd && i_addr == 7'h15
      ##1 i_rd && i_addr == 7'h15 |=> o_rdata == 8'h00;
  endproperty
  a_qerr: assert property (p_qerr) else $error("crc flag kept");
  property p_uptr;
    i_wr && i_addr == 7'h16 && i_wdata < 8'h2f ##1 i_rd && i_addr == 7'h16
      |=> o_rdata == $past(i_wdata, 2);
  endproperty
  a_uptr: assert property (p_uptr) else $error("pointer lost");
  property p_uadv;
    i_wr && i_addr == 7'h16 && i_wdata < 8'h2f ##1 i_rd && i_addr == 7'h17
      ##1 i_rd && i_addr == 7'h16 |=> o_rdata == $past(i_wdata, 3) + 8'h01;
  endproperty
  a_uadv: assert property (p_uadv) else $error("pointer not bumped");
  c_udat: cover property (i_rd && i_addr == 7'h17);
  c_tx: cover property (i_tx_bit);
  c_irq: cover property (o_irq);
endmodule // spdif_buf_chk

bind spdif_status_user_buffers spdif_buf_chk u_chk (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq),
  .i_rx_bit(i_rx_bit), .i_tx_bit(i_tx_bit), .o_tx_cs(o_tx_cs),
  .o_tx_user(o_tx_user));

//--- dv/spdif_link_model.sv
// Purpose: Frame coder stand-in giving subframe strobes
// Assumes: Strobes three clocks apart, channel A then B
// Notes:   Bit lines flip between strobes so stale values show
module spdif_link_model (
  input  wire logic i_clk,  // Clock
  input  wire logic i_go,   // Start one block
  output logic      o_stb,  // Subframe strobe
  output logic      o_chb,  // Channel B subframe
  output logic      o_z,    // Frame with Z preamble
  output logic      o_cs,   // Status bit
  output logic      o_ub,   // User bit
  output logic      o_busy  // Block running
);
  timeunit 1ns;
  timeprecision 1ns;
  int seed = 32'h0ec3; // Fixed seed
  // One block of 192 frames per start pulse
  initial begin
    {o_stb, o_chb, o_z, o_cs, o_ub, o_busy} = '0;
    forever begin
      do @(posedge i_clk); while (!i_go);
      o_busy <= 1'b1;
      for (int s = 0; s < 384; s++) begin
        o_stb <= 1'b1;
        o_chb <= s[0];
        o_z <= s < 2;
        {o_cs, o_ub} <= 2'($random(seed));
        @(posedge i_clk);
        o_stb <= 1'b0;
        {o_cs, o_ub} <= ~{o_cs, o_ub};
        repeat (2) @(posedge i_clk);
      end
      o_busy <= 1'b0;
    end
  end
endmodule // spdif_link_model

//--- dv/spdif_status_user_buffers_test.sv
// Purpose: Self-checking bench for the status and user buffers
// Assumes: One 20 MHz clock; link model drives rx and tx strobes
// Notes:   Tx user mode stays 00, so tx user bits must read zero
module spdif_status_user_buffers_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, rd_s, wr_s, go, stb, chb, z, rcs, rub, busy, irq;
  logic       tcs, tub, tpend, rpend; // Tx outputs, check pipes
  logic [6:0] addr;                   // Bus address
  logic [7:0] wdata, rdata, txe[24];  // Bus data, tx bytes
  logic [7:0] eq[$];                  // Expected read data
  bit         cs[2][192], ub[384];    // Captured link bits
  int         sn, tfr, cyc, bad_count, cmp_count;
  spdif_status_user_buffers dut (.i_clk(clk), .i_rst_n(rst_n), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .o_irq(irq),
    .i_rx_bit(stb), .i_rx_chan_b(chb), .i_rx_zblk(z), .i_rx_cs(rcs),
    .i_rx_user(rub), .i_tx_bit(stb), .i_tx_chan_b(chb), .i_tx_zblk(z),
    .o_tx_cs(tcs), .o_tx_user(tub));
  spdif_link_model far (.i_clk(clk), .i_go(go), .o_stb(stb), .o_chb(chb),
    .o_z(z), .o_cs(rcs), .o_ub(rub), .o_busy(busy));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    if (bad_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Bus cycles hold the strobe up between back-to-back transfers
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    addr <= a; wdata <= d; wr_s <= 1'b1; rd_s <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    addr <= a; rd_s <= 1'b1; wr_s <= 1'b0; eq.push_back(e);
    @(posedge clk);
  endtask
  // One link block from a Z frame; frame count restarts for tx checks
  task automatic blk();
    sn = 0;
    {go, wr_s} <= 2'b10;
    @(posedge clk);
    go <= 1'b0;
    wait (busy);
    wait (!busy);
  endtask
  function automatic logic [7:0] csb(int c, int j);
    for (int i = 0; i < 8; i++) csb[i] = cs[c][8 * j + i];
  endfunction
  function automatic logic [7:0] ubb(int j);
    for (int i = 0; i < 8; i++) ubb[7 - i] = ub[8 * j + i];
  endfunction
  // Model capture, read data and tx bit checks, hang limit
  always @(posedge clk) begin
    tpend <= stb;
    rpend <= rd_s;
    if (rpend) check(rdata, eq.pop_front());
    if (tpend) check({7'h00, tcs}, {7'h00, txe[tfr / 8][tfr % 8]});
    if (tpend) check({7'h00, tub}, 8'h00);
    if (stb) begin
      tfr <= sn / 2; cs[chb][sn / 2] = rcs; ub[sn] = rub; sn++;
    end
    if (++cyc > 9000) begin bad_count++; wrap_up(); end
  end
  initial begin
    {rst_n, rd_s, wr_s, go, addr, wdata} = '0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rd(7'h20, 8'h00);
    rd(7'h7f, 8'h00);
    wr(7'h10, 8'h02);
    wr(7'h14, 8'h07);
    wr(7'h12, 8'h04);
    for (int j = 0; j < 24; j++) begin
      txe[j] = 8'(j * 37 + 5);
      wr(7'h38 + 7'(j), txe[j]);
    end
    blk();
    repeat (4) @(posedge clk);
    check({7'h00, irq}, 8'h01);
    rd(7'h13, 8'h03);
    rd(7'h13, 8'h00);
    for (int c = 0; c < 2; c++) begin
      wr(7'h12, 8'h04 | 8'(c));
      for (int j = 0; j < 24; j++) rd(7'h20 + 7'(j), csb(c, j));
    end
    wr(7'h16, 8'h00);
    for (int j = 0; j < 48; j++) rd(7'h17, ubb(j));
    wr(7'h16, 8'h05);
    rd(7'h17, ubb(5));
    rd(7'h16, 8'h06);
    wr(7'h16, 8'h09);
    rd(7'h16, 8'h09);
    rd(7'h15, 8'h00);
    rd(7'h15, 8'h00);
    check({7'h00, irq}, 8'h00);
    // Copy held: new host byte must not reach the link
    wr(7'h12, 8'h0c);
    wr(7'h38, ~txe[0]);
    blk();
    rd_s <= 1'b0;
    repeat (3) @(posedge clk);
    wrap_up();
  end
endmodule // spdif_status_user_buffers_test
